/* src/ring_alarm_pkg.sv */
package ring_alarm_pkg;

  // Clock and time base
  localparam int CLOCK_HZ = 20_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  localparam int MS_PER_S = 1000;
  localparam int SEC_TICK_MS = MS_PER_S / TICK_MS;
  localparam int NO_TOKEN_MS = 40;
  localparam int NO_TOKEN_TICKS = NO_TOKEN_MS / TICK_MS;
  localparam int STROKE_MS = 200;
  localparam int STROKE_TICKS = STROKE_MS / TICK_MS;
  localparam int SELFTEST_S = 4;
  localparam int NOFAC_S = 4;
  localparam int FAIL_S = 4;
  localparam int RECOVER_S = 12;

  // Register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] SILENCE_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] FACILITY_OFS = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control fields
  localparam int CTRL_W = 4;
  localparam int CTRL_CRIT = 0;
  localparam int CTRL_MAJOR = 1;
  localparam int CTRL_MINOR = 2;
  localparam int CTRL_INIT = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  // Pin inputs, index into the synchronised vector
  localparam int PIN_W = 20;
  localparam int P_ACC_ERR = 0;
  localparam int P_DRV_FLT = 1;
  localparam int P_RING_FLT = 2;
  localparam int P_FUSE = 3;
  localparam int P_BOARD_OUT = 4;
  localparam int P_RECONFIG = 5;
  localparam int P_RING_DOWN = 6;
  localparam int P_PCN_AUTO = 7;
  localparam int P_LNODE_OUT = 8;
  localparam int P_LINK_OUT = 9;
  localparam int P_PWR_FAIL = 10;
  localparam int P_NODE_OUT = 11;
  localparam int P_TOKEN_A = 12;
  localparam int P_TOKEN_B = 13;
  localparam int P_RESET_BTN = 14;
  localparam int P_TEST_PASS = 15;
  localparam int P_FAC_CONN = 16;
  localparam int P_UNIT_FAIL = 17;
  localparam int P_NEAR_FAIL = 18;
  localparam int P_FAR_FAIL = 19;

  // Event bits, sticky and write-one-to-clear
  localparam int EV_W = 9;
  localparam int EV_CRIT = 0;
  localparam int EV_MAJOR = 1;
  localparam int EV_MINOR = 2;
  localparam int EV_PLANT = 3;
  localparam int EV_VISUAL = 4;
  localparam int EV_NO_TOKEN = 5;
  localparam int EV_UNIT = 6;
  localparam int EV_NEAR = 7;
  localparam int EV_FAR = 8;

  typedef enum logic [2:0] {
    FAC_TEST, FAC_NOFAC, FAC_TESTFAIL, FAC_NORMAL,
    FAC_PEND, FAC_ALARM, FAC_RECOVER
  } fac_state_t;

endpackage : ring_alarm_pkg

/* src/tick_divider.sv */
`timescale 1ns/1ps
// Emits a one-cycle tick every COUNT enabled cycles
module tick_divider #(
  parameter int COUNT = 1000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Rate
  input wire logic enable,
  output logic tick
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
  logic [CW-1:0] cnt_q;
  wire logic wrap = enable && (cnt_q == LAST);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= wrap;
      if (enable) begin
        cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      end
    end
  end
endmodule : tick_divider

/* src/ring_alarm_indicator_logic.sv */
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Critical alarm: two tone-bar strokes and critical display indicator.
// - Major alarm from hardware or software faults: one tone-bar stroke.
// - Minor alarm rings the bell and shows the lowest indicator.
// - Power plant major rings the bell with no display indicator.
// - Access, driver, init, auto removal, ring, fuse, board, reconfig sound.
// - Every alarm condition is reported to the host, any severity.
// - Silence stops sound only; visual indicators hold until normal.
// - Visual alarm on node, link removal, reconfig, ring down, power fail.
// - Quarantine lamp lit while out of service, even on the ring.
// - No-token lamp lit when neither ring access circuit sees a token.
// - Ring inactive after more than 40 ms without a token.
// - Power alarm lamp lit on blown fuse or unplugged power board.
// - LEDs: red near-end, yellow far-end, green normal, red+green test fail.
// - Reset press: LEDs off, self-test; pass and connected gives green at 4 s.
// - Pass with no facility: green at 4 s, then red only 4 s later.
// - Self-test failure lights red and green at 4 s.
// - Near or far failure lights red or yellow after 4 s, green off.
// - After the failure clears, green returns after 12 s, red/yellow off.
// - Unit failure masks all; near-end failure masks far-end.
// - Far-end failure reported again when masking near-end failure clears.
// - Far-end beginning under near-end is reported only after it clears.
module ring_alarm_indicator_logic #(
  parameter int MS_CYCLES = ring_alarm_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [ring_alarm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ring_alarm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ring and facility condition pins
  input wire logic [ring_alarm_pkg::PIN_W-1:0] condition_pins,
  // Office alarms and display
  output logic tone_bar,
  output logic bell,
  output logic [2:0] maintenance_display_indicator,
  output logic visual_alarm,
  // Lamps
  output logic quarantine_lamp,
  output logic no_token_lamp,
  output logic power_alarm_lamp,
  // Facility LEDs
  output logic led_red,
  output logic led_yellow,
  output logic led_green
);
  // Pins cross in through two flops; only the second stage is used
  logic [ring_alarm_pkg::PIN_W-1:0] pin_meta_q;
  logic [ring_alarm_pkg::PIN_W-1:0] pin_q;
  logic [ring_alarm_pkg::PIN_W-1:0] pin_prev_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_meta_q <= '0;
      pin_q <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_meta_q <= condition_pins;
      pin_q <= pin_meta_q;
      pin_prev_q <= pin_q;
    end
  end

  // Time base
  logic ms_tick;
  logic sec_tick;

  tick_divider #(.COUNT(MS_CYCLES)) u_ms_div (
    .clock(clock),
    .reset_n(reset_n),
    .enable(1'b1),
    .tick(ms_tick)
  );

  tick_divider #(.COUNT(ring_alarm_pkg::SEC_TICK_MS)) u_sec_div (
    .clock(clock),
    .reset_n(reset_n),
    .enable(ms_tick),
    .tick(sec_tick)
  );

  // Software controls
  logic [ring_alarm_pkg::CTRL_W-1:0] ctrl_q;
  logic silence_q;
  logic [ring_alarm_pkg::EV_W-1:0] event_q;

  // Severity classes
  wire logic crit_cond = ctrl_q[ring_alarm_pkg::CTRL_CRIT];
  wire logic major_cond = ctrl_q[ring_alarm_pkg::CTRL_MAJOR]
    | ctrl_q[ring_alarm_pkg::CTRL_INIT]
    | pin_q[ring_alarm_pkg::P_ACC_ERR]
    | pin_q[ring_alarm_pkg::P_DRV_FLT]
    | pin_q[ring_alarm_pkg::P_RING_FLT]
    | pin_q[ring_alarm_pkg::P_RECONFIG]
    | pin_q[ring_alarm_pkg::P_PCN_AUTO];
  wire logic minor_cond = ctrl_q[ring_alarm_pkg::CTRL_MINOR];
  wire logic power_lamp_cond = pin_q[ring_alarm_pkg::P_FUSE]
    | pin_q[ring_alarm_pkg::P_BOARD_OUT];
  wire logic plant_cond = power_lamp_cond;
  wire logic visual_cond = pin_q[ring_alarm_pkg::P_PCN_AUTO]
    | pin_q[ring_alarm_pkg::P_LNODE_OUT]
    | pin_q[ring_alarm_pkg::P_LINK_OUT]
    | pin_q[ring_alarm_pkg::P_RECONFIG]
    | pin_q[ring_alarm_pkg::P_RING_DOWN]
    | pin_q[ring_alarm_pkg::P_PWR_FAIL];
  wire logic audible_any = crit_cond | major_cond | minor_cond | plant_cond;

  // Token watch, one timer per ring access circuit
  localparam int TW = $clog2(ring_alarm_pkg::NO_TOKEN_TICKS + 2);
  localparam logic [TW-1:0] TOK_LIMIT = TW'(ring_alarm_pkg::NO_TOKEN_TICKS);
  logic [1:0] token_lost;

  for (genvar i = 0; i < 2; i++) begin : g_token
    logic [TW-1:0] since_q;
    wire logic seen = pin_q[ring_alarm_pkg::P_TOKEN_A + i]
      & ~pin_prev_q[ring_alarm_pkg::P_TOKEN_A + i];
    // Saturates just past the limit so "more than" holds
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        since_q <= '0;
      end else if (seen) begin
        since_q <= '0;
      end else if (ms_tick && since_q <= TOK_LIMIT) begin
        since_q <= since_q + 1'b1;
      end
    end
    assign token_lost[i] = since_q > TOK_LIMIT;
  end

  wire logic no_token_cond = &token_lost;

  // Facility failure masking, most severe first
  wire logic unit_fail = pin_q[ring_alarm_pkg::P_UNIT_FAIL];
  wire logic near_eff = pin_q[ring_alarm_pkg::P_NEAR_FAIL]
    & ~unit_fail;
  wire logic far_eff = pin_q[ring_alarm_pkg::P_FAR_FAIL]
    & ~pin_q[ring_alarm_pkg::P_NEAR_FAIL] & ~unit_fail;

  // Conditions whose onset is reported to the host
  wire logic [ring_alarm_pkg::EV_W-1:0] report_vec = {
    far_eff, near_eff, unit_fail, no_token_cond, visual_cond,
    plant_cond, minor_cond, major_cond, crit_cond
  };
  logic [ring_alarm_pkg::EV_W-1:0] report_prev_q;
  // A far-end that persists shows a fresh rise once unmasked
  wire logic [ring_alarm_pkg::EV_W-1:0] report_rise =
    report_vec & ~report_prev_q;
  wire logic audible_rise = |report_rise[ring_alarm_pkg::EV_PLANT:0];

  // AXI4-Lite write side
  logic aw_have_q;
  logic w_have_q;
  logic [ring_alarm_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  wire logic wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  wire logic wr_ctrl = wr_go && aw_addr_q == ring_alarm_pkg::CTRL_OFS;
  wire logic wr_sil = wr_go && aw_addr_q == ring_alarm_pkg::SILENCE_OFS;
  wire logic wr_ev = wr_go && aw_addr_q == ring_alarm_pkg::EVENT_OFS;
  wire logic wr_ok = wr_ctrl || wr_sil || wr_ev
    || aw_addr_q == ring_alarm_pkg::STATUS_OFS
    || aw_addr_q == ring_alarm_pkg::FACILITY_OFS;
  wire logic lane0 = w_strb_q[0];
  wire logic lane1 = w_strb_q[1];
  wire logic [ring_alarm_pkg::EV_W-1:0] ev_clear = {
    w_data_q[8] & lane1, w_data_q[7:0] & {8{lane0}}
  };

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ring_alarm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ring_alarm_pkg::RESP_OKAY
                             : ring_alarm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control, silence and event registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_q <= ring_alarm_pkg::CTRL_RESET;
      silence_q <= 1'b0;
      event_q <= '0;
      report_prev_q <= '0;
    end else begin
      report_prev_q <= report_vec;
      if (wr_ctrl && lane0) begin
        ctrl_q <= w_data_q[ring_alarm_pkg::CTRL_W-1:0];
      end
      // Silence only mutes; a new alarm or a quiet office re-arms it
      if (wr_sil && lane0 && w_data_q[0]) begin
        silence_q <= 1'b1;
      end else if (audible_rise || !audible_any) begin
        silence_q <= 1'b0;
      end
      // New onsets win over a clear in the same cycle
      event_q <= (event_q & ~(wr_ev ? ev_clear : '0))
        | report_rise;
    end
  end

  // Tone bar strokes
  localparam int SW = $clog2(2 * ring_alarm_pkg::STROKE_TICKS + 1);
  localparam logic [SW-1:0] STROKE_END =
    SW'(2 * ring_alarm_pkg::STROKE_TICKS - 1);
  localparam logic [SW-1:0] STROKE_ON = SW'(ring_alarm_pkg::STROKE_TICKS);
  logic [1:0] strokes_q;
  logic [SW-1:0] stroke_t_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      strokes_q <= 2'h0;
      stroke_t_q <= '0;
    end else if (silence_q) begin
      strokes_q <= 2'h0;
      stroke_t_q <= '0;
    end else if (report_rise[ring_alarm_pkg::EV_CRIT]) begin
      strokes_q <= 2'h2;
      stroke_t_q <= '0;
    end else if (report_rise[ring_alarm_pkg::EV_MAJOR]
        && strokes_q == 2'h0) begin
      strokes_q <= 2'h1;
      stroke_t_q <= '0;
    end else if (ms_tick && strokes_q != 2'h0) begin
      if (stroke_t_q == STROKE_END) begin
        stroke_t_q <= '0;
        strokes_q <= strokes_q - 2'h1;
      end else begin
        stroke_t_q <= stroke_t_q + 1'b1;
      end
    end
  end

  // Facility self-test and failure indication
  ring_alarm_pkg::fac_state_t fac_q;
  ring_alarm_pkg::fac_state_t fac_d;
  logic [3:0] sec_q;
  logic red_sel_q;
  wire logic press = pin_q[ring_alarm_pkg::P_RESET_BTN]
    & ~pin_prev_q[ring_alarm_pkg::P_RESET_BTN];
  wire logic fac_fail = near_eff | far_eff;

  function automatic logic elapsed(input logic [3:0] s, input int lim);
    elapsed = s >= 4'(lim);
  endfunction : elapsed

  always_comb begin
    fac_d = fac_q;
    case (fac_q)
      ring_alarm_pkg::FAC_TEST: begin
        if (elapsed(sec_q, ring_alarm_pkg::SELFTEST_S)) begin
          if (!pin_q[ring_alarm_pkg::P_TEST_PASS]) begin
            fac_d = ring_alarm_pkg::FAC_TESTFAIL;
          end else if (!pin_q[ring_alarm_pkg::P_FAC_CONN]) begin
            fac_d = ring_alarm_pkg::FAC_NOFAC;
          end else begin
            fac_d = ring_alarm_pkg::FAC_NORMAL;
          end
        end
      end
      ring_alarm_pkg::FAC_NOFAC: begin
        if (elapsed(sec_q, ring_alarm_pkg::NOFAC_S)) begin
          fac_d = ring_alarm_pkg::FAC_ALARM;
        end
      end
      ring_alarm_pkg::FAC_TESTFAIL: fac_d = ring_alarm_pkg::FAC_TESTFAIL;
      ring_alarm_pkg::FAC_NORMAL: begin
        if (fac_fail) begin
          fac_d = ring_alarm_pkg::FAC_PEND;
        end
      end
      ring_alarm_pkg::FAC_PEND: begin
        if (!fac_fail) begin
          fac_d = ring_alarm_pkg::FAC_NORMAL;
        end else if (elapsed(sec_q, ring_alarm_pkg::FAIL_S)) begin
          fac_d = ring_alarm_pkg::FAC_ALARM;
        end
      end
      ring_alarm_pkg::FAC_ALARM: begin
        if (!fac_fail && pin_q[ring_alarm_pkg::P_FAC_CONN]) begin
          fac_d = ring_alarm_pkg::FAC_RECOVER;
        end
      end
      ring_alarm_pkg::FAC_RECOVER: begin
        if (fac_fail) begin
          fac_d = ring_alarm_pkg::FAC_ALARM;
        end else if (elapsed(sec_q, ring_alarm_pkg::RECOVER_S)) begin
          fac_d = ring_alarm_pkg::FAC_NORMAL;
        end
      end
      default: fac_d = ring_alarm_pkg::FAC_TEST;
    endcase
    if (press) begin
      fac_d = ring_alarm_pkg::FAC_TEST;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fac_q <= ring_alarm_pkg::FAC_TEST;
      sec_q <= 4'h0;
      red_sel_q <= 1'b1;
    end else begin
      fac_q <= fac_d;
      if (fac_d != fac_q || press) begin
        sec_q <= 4'h0;
      end else if (sec_tick && sec_q != 4'hf) begin
        sec_q <= sec_q + 4'h1;
      end
      // Which lamp an alarm shows; a missing facility reads as near-end
      if (fac_q == ring_alarm_pkg::FAC_NOFAC) begin
        red_sel_q <= 1'b1;
      end else if (fac_fail) begin
        red_sel_q <= near_eff;
      end
    end
  end

  // Registered outputs
  wire logic in_alarm = fac_q == ring_alarm_pkg::FAC_ALARM
    || fac_q == ring_alarm_pkg::FAC_RECOVER;
  wire logic show_green = fac_q == ring_alarm_pkg::FAC_NORMAL
    || fac_q == ring_alarm_pkg::FAC_PEND || fac_q == ring_alarm_pkg::FAC_NOFAC
    || fac_q == ring_alarm_pkg::FAC_TESTFAIL;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tone_bar <= 1'b0;
      bell <= 1'b0;
      maintenance_display_indicator <= 3'h0;
      visual_alarm <= 1'b0;
      quarantine_lamp <= 1'b0;
      no_token_lamp <= 1'b0;
      power_alarm_lamp <= 1'b0;
      led_red <= 1'b0;
      led_yellow <= 1'b0;
      led_green <= 1'b0;
    end else begin
      tone_bar <= strokes_q != 2'h0 && stroke_t_q < STROKE_ON;
      bell <= (minor_cond | plant_cond) & ~silence_q;
      // Display bit 2 critical, 1 major, 0 minor; power plant has none
      maintenance_display_indicator <=
        {crit_cond, major_cond, minor_cond};
      visual_alarm <= visual_cond;
      quarantine_lamp <= pin_q[ring_alarm_pkg::P_NODE_OUT];
      no_token_lamp <= no_token_cond;
      power_alarm_lamp <= power_lamp_cond;
      led_red <= fac_q == ring_alarm_pkg::FAC_TESTFAIL
        || (in_alarm && red_sel_q);
      led_yellow <= in_alarm && !red_sel_q;
      led_green <= show_green;
    end
  end

  // AXI4-Lite read side
  wire logic [31:0] status_word = {
    19'h0, no_token_cond, silence_q, strokes_q != 2'h0, plant_cond,
    visual_cond, power_lamp_cond, pin_q[ring_alarm_pkg::P_NODE_OUT],
    token_lost, minor_cond, major_cond, crit_cond, bell
  };
  wire logic [31:0] fac_word = {
    22'h0, 3'(fac_q), sec_q, led_red, led_yellow, led_green
  };
  wire logic rd_hit = s_axi_araddr == ring_alarm_pkg::CTRL_OFS
    || s_axi_araddr == ring_alarm_pkg::SILENCE_OFS
    || s_axi_araddr == ring_alarm_pkg::STATUS_OFS
    || s_axi_araddr == ring_alarm_pkg::EVENT_OFS
    || s_axi_araddr == ring_alarm_pkg::FACILITY_OFS;
  logic [31:0] rd_word;

  always_comb begin
    case (s_axi_araddr)
      ring_alarm_pkg::CTRL_OFS: rd_word = 32'(ctrl_q);
      ring_alarm_pkg::SILENCE_OFS: rd_word = 32'(silence_q);
      ring_alarm_pkg::STATUS_OFS: rd_word = status_word;
      ring_alarm_pkg::EVENT_OFS: rd_word = 32'(event_q);
      ring_alarm_pkg::FACILITY_OFS: rd_word = fac_word;
      default: rd_word = 32'h0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ring_alarm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? ring_alarm_pkg::RESP_OKAY
                            : ring_alarm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ring_alarm_indicator_logic

/* sim/token_source.sv */
`timescale 1ns/1ps
// Ring traffic: one token pulse every GAP cycles on each live line
module token_source #(
  parameter int GAP = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Live access circuits
  input wire logic [1:0] run,
  // Token lines, a rising edge is a token
  output logic [1:0] token
);
  logic [7:0] cnt_q;
  always_ff @(posedge clock) begin
    if (!reset_n || cnt_q == 8'(GAP - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // A dead circuit sits low, so it shows no edge that could pass for a token
  always_ff @(posedge clock) begin
    token <= run & {2{cnt_q == 8'h00}};
  end
endmodule : token_source

/* sim/ring_alarm_assertions.sv */
`timescale 1ns/1ps
module ring_alarm_checker #(
  parameter int MS_CYCLES = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Watched ports
  input wire logic [19:0] condition_pins,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic tone_bar,
  input wire logic visual_alarm,
  input wire logic quarantine_lamp,
  input wire logic no_token_lamp,
  input wire logic power_alarm_lamp,
  input wire logic led_red,
  input wire logic led_yellow,
  input wire logic led_green
);
  localparam int SEC = 1000 * MS_CYCLES;
  logic [31:0] tok_q;
  logic [31:0] prs_q;
  logic [31:0] hi_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // The token and press counters saturate so a long quiet spell never wraps to zero
  always_ff @(posedge clock) begin
    if (!reset_n || $rose(condition_pins[12]) || $rose(condition_pins[13]))
      tok_q <= '0;
    else if (~&tok_q)
      tok_q <= tok_q + 32'h1;
  end
  always_ff @(posedge clock) begin
    if (!reset_n || $rose(condition_pins[14]))
      prs_q <= '0;
    else if (~&prs_q)
      prs_q <= prs_q + 32'h1;
  end
  always_ff @(posedge clock) begin
    hi_q <= (reset_n && tone_bar) ? hi_q + 32'h1 : '0;
  end
  sequence s_press;
    $rose(condition_pins[14]);
  endsequence
  sequence s_dark;
    !led_red && !led_yellow && !led_green;
  endsequence
  AST_PRESS_DARK: assert property (s_press |-> ##5 s_dark)
    else $error("leds lit after press");
  AST_GREEN_EARLY: assert property ($rose(led_green) |->
    prs_q >= 3 * SEC)
    else $error("green too soon");
  AST_STROKE_LEN: assert property ($fell(tone_bar) |->
    hi_q >= 199 * MS_CYCLES && hi_q <= 201 * MS_CYCLES)
    else $error("stroke length");
  AST_PWR_LAMP: assert property ($past(reset_n, 3) |->
    power_alarm_lamp == |$past(condition_pins[4:3], 3))
    else $error("power lamp");
  AST_QUAR_LAMP: assert property ($past(reset_n, 3) |->
    quarantine_lamp == $past(condition_pins[11], 3))
    else $error("quarantine lamp");
  AST_VISUAL: assert property ($past(reset_n, 3) &&
    |$past(condition_pins[10:5], 3) |-> visual_alarm)
    else $error("visual alarm");
  AST_LED_YELLOW: assert property (led_yellow |->
    !led_red && !led_green)
    else $error("yellow with other led");
  AST_NT_EARLY: assert property ($rose(no_token_lamp) |->
    tok_q >= 39 * MS_CYCLES)
    else $error("no-token lamp early");
  AST_NT_LATE: assert property (tok_q == 42 * MS_CYCLES + 10 |->
    no_token_lamp)
    else $error("no-token lamp late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule : ring_alarm_checker
bind ring_alarm_indicator_logic ring_alarm_checker #(
  .MS_CYCLES(MS_CYCLES)
) chk (
  .clock(clock), .reset_n(reset_n), .condition_pins(condition_pins),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .tone_bar(tone_bar),
  .visual_alarm(visual_alarm), .quarantine_lamp(quarantine_lamp),
  .no_token_lamp(no_token_lamp), .power_alarm_lamp(power_alarm_lamp),
  .led_red(led_red), .led_yellow(led_yellow), .led_green(led_green)
);

/* sim/ring_alarm_indicator_logic_bench.sv */
`timescale 1ns/1ps
module ring_alarm_indicator_logic_bench;
  logic clock, reset_n;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, tok, run;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, tone_bar, bell, visual_alarm;
  logic quarantine_lamp, no_token_lamp, power_alarm_lamp;
  logic led_red, led_yellow, led_green;
  logic [2:0] disp;
  logic [19:0] pins;
  wire logic [19:0] cpins = {pins[19:14], tok, pins[11:0]};
  logic [1:0] wr_q[$];
  logic [33:0] rd_q[$];
  logic [33:0] mk_q[$];
  logic [33:0] e, m;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  localparam logic [19:0] AUD = 20'h000bf;
  localparam logic [19:0] VIS = 20'h007e0;
  ring_alarm_indicator_logic #(.MS_CYCLES(2)) uut (
    .clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .condition_pins(cpins), .tone_bar,
    .bell, .maintenance_display_indicator(disp), .visual_alarm,
    .quarantine_lamp, .no_token_lamp, .power_alarm_lamp, .led_red,
    .led_yellow, .led_green
  );
  token_source #(.GAP(20)) far (.clock, .reset_n, .run, .token(tok));
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic bad(input string s);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, s);
  endtask : bad
  task automatic chk(input logic g, input string s);
    checks_done++;
    if (g !== 1'b1) bad(s);
  endtask : chk
  task automatic hold(input int c);
    repeat (c) @(posedge clock);
  endtask : hold
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clock);
    wr_q.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [33:0] x, k);
    @(posedge clock);
    rd_q.push_back(x);
    mk_q.push_back(k);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic strokes(output int c);
    logic p;
    c = 0;
    p = tone_bar;
    repeat (2000) begin
      @(posedge clock);
      if (tone_bar && !p) c++;
      p = tone_bar;
    end
  endtask : strokes
  // Responses are matched in issue order; one transfer is open at a time
  always @(posedge clock) begin
    cycles++;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = rd_q.pop_front();
      m = mk_q.pop_front();
      checks_done++;
      if (({s_axi_rresp, s_axi_rdata} & m) !== (e & m)) bad("read data");
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      checks_done++;
      if (s_axi_bresp !== wr_q.pop_front()) bad("write response");
    end
    if (cycles == 90000) begin
      bad("timeout");
      conclude();
    end
  end
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    pins = 20'h18000;
    run = 2'b11;
    void'($urandom(32'h0e94c328));
    hold(20);
    reset_n <= 1'b1;
    hold(2);
    rd(5'h14, {2'h2, 32'h0}, '1);
    wr(5'h14, 32'h1, 2'h2);
    rnd = $urandom() & 32'hf;
    wr(5'h00, rnd, 2'h0);
    rd(5'h00, {2'h0, rnd}, '1);
    wr(5'h00, 32'h0, 2'h0);
    pins[14] <= 1'b1;
    hold(2);
    pins[14] <= 1'b0;
    hold(8);
    chk(!(led_red | led_yellow | led_green), "leds lit");
    hold(5790);
    chk(!led_green, "green early");
    hold(3200);
    chk(led_green & !led_red, "no green");
    rd(5'h10, 34'h1, 34'h7);
    pins[18] <= 1'b1;
    hold(5800);
    chk(led_green & !led_red, "red early");
    hold(3200);
    chk(led_red & !led_green & !led_yellow, "no red");
    pins[19] <= 1'b1;
    hold(10);
    wr(5'h0c, 32'h1ff, 2'h0);
    rd(5'h0c, 34'h0, 34'h100);
    pins[18] <= 1'b0;
    hold(10);
    rd(5'h0c, 34'h100, 34'h100);
    chk(led_yellow & !led_red, "no yellow");
    pins[19] <= 1'b0;
    hold(21600);
    chk(!led_green, "recovery early");
    hold(3600);
    chk(led_green & !led_red & !led_yellow, "no recovery");
    wr(5'h00, 32'h1, 2'h0);
    strokes(n);
    chk(n == 2 && disp[2], "critical");
    wr(5'h00, 32'h2, 2'h0);
    strokes(n);
    chk(n == 1 && disp[1], "major");
    wr(5'h00, 32'h4, 2'h0);
    hold(8);
    chk(bell & disp[0], "minor");
    wr(5'h04, 32'h1, 2'h0);
    hold(8);
    chk(!bell & disp[0], "silence");
    rd(5'h04, 34'h1, 34'h1);
    rd(5'h0c, 34'h7, 34'h7);
    wr(5'h00, 32'h0, 2'h0);
    for (int i = 0; i < 12; i++) begin
      pins[i] <= 1'b1;
      hold(8);
      chk(tone_bar | bell | !AUD[i], "no audible");
      chk(visual_alarm | !VIS[i], "no visual");
      chk(power_alarm_lamp == (i == 3 || i == 4), "power");
      chk(quarantine_lamp == (i == 11), "quarantine");
      pins[i] <= 1'b0;
      hold(1200);
    end
    run <= 2'b01;
    hold(200);
    chk(!no_token_lamp, "lamp, one ring live");
    run <= 2'b00;
    hold(50);
    chk(!no_token_lamp, "lamp early");
    hold(70);
    chk(no_token_lamp, "no lamp");
    conclude();
  end
endmodule : ring_alarm_indicator_logic_bench
